// >>> uscr_pkg.sv
package uscr_pkg;
	localparam int BAUD_W = 16;
	localparam int BAUD_FRAC_W = 6;
	localparam logic [1:0] RECEIVE_SPEED_MODE_NORMAL = 2'h0;
	localparam logic [1:0] RECEIVE_SPEED_MODE_DOUBLE = 2'h1;
	localparam logic [4:0] SPB_NORMAL = 5'h10;
	localparam logic [4:0] SPB_DOUBLE = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [3:0] SPI_FRAME_BITS = 4'h8;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_WIDTH = 8;

	typedef enum logic [1:0] {
		USCR_MODE_ASYNC = 2'h0,
		USCR_MODE_SYNC = 2'h1,
		USCR_MODE_SPI = 2'h3
	} uscr_mode_t;

	typedef struct packed {
		uscr_mode_t mode;
		logic clk_master;
		logic pin_inversion_enable;
		logic clock_phase_select;
		logic bit_order_select;
		logic [1:0] receive_speed_mode;
		logic [BAUD_W-1:0] baud;
	} uscr_cfg_t;

	typedef struct packed {
		logic frame_err;
		logic overflow_err;
		logic parity_err;
	} uscr_err_t;

	typedef enum logic [1:0] {
		USCR_RX_IDLE = 2'h0,
		USCR_RX_START = 2'h1,
		USCR_RX_DATA = 2'h3
	} uscr_rx_state_t;
endpackage

// >>> uscr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module uscr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q, rp_q;
	logic [AW:0] cnt;
	assign cnt = wp_q - rp_q;
	assign wr_ready_out = cnt != (AW+1)'(DEPTH);
	assign rd_valid_out = cnt != '0;
	assign rd_data_out = mem_q[rp_q[AW-1:0]];
	always_ff @(posedge clk_in) begin
		if (wr_valid_in && wr_ready_out) begin
			mem_q[wp_q[AW-1:0]] <= wr_data_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (wr_valid_in && wr_ready_out) begin
				wp_q <= wp_q + 1'b1;
			end
			if (rd_valid_out && rd_ready_in) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> uscr_top.sv
//
// What this block does
// - clock pin drives as master, listens as slave
// - sample on edge opposite the shift edge
// - inversion clear: shift rising, sample falling
// - inversion set: shift falling, sample rising
// - slave rate set only by external clock
// - spi frames are exactly eight data bits
// - bit order selects lsb or msb first
// - spi master generates and drives the clock
// - bit held one period, sampled mid-period
// - inversion and phase choose edge roles
// - spi transmit path behaves as usual
// - spi error flags always read zero
// - no collision, double-speed, multimaster or select
// - receive mode picks 16x or 8x sampling
// - falling edge from idle starts detection
// - vote samples 8-10 normal, 4-6 double
// - majority low accepts start, else rearm
// - master clock is clk over twice baud integer
`timescale 1ns/100ps
`default_nettype none
module uscr_top
	import uscr_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// configuration
	input wire uscr_pkg::uscr_cfg_t cfg_in,
	// serial clock pin
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_out,
	// data pins
	input wire logic rxd_in,
	output logic txd_out,
	// transmit byte stream
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	// received byte stream
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in,
	// async clock recovery, error flags and busy
	input wire logic sample_tick_in,
	output logic start_ok_out,
	output logic bit_tick_out,
	output uscr_pkg::uscr_err_t err_out,
	output logic busy_out
);
	import uscr_pkg::*;

	logic sync_mode;
	logic slave;
	assign sync_mode = cfg_in.mode != USCR_MODE_ASYNC;
	assign slave = sync_mode && !cfg_in.clk_master;

	// three-stage input capture; a change counts when the last two agree
	logic [2:0] xck_s_q;
	logic [2:0] rxd_s_q;
	logic xck_lvl_q, rxd_lvl_q;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			xck_s_q <= '0;
			rxd_s_q <= 3'h7;
			xck_lvl_q <= 1'b0;
			rxd_lvl_q <= 1'b1;
		end else begin
			xck_s_q <= {xck_s_q[1:0], serial_clock_pin_in};
			rxd_s_q <= {rxd_s_q[1:0], rxd_in};
			if (xck_s_q[1] == xck_s_q[2]) begin
				xck_lvl_q <= xck_s_q[2];
			end
			if (rxd_s_q[1] == rxd_s_q[2]) begin
				rxd_lvl_q <= rxd_s_q[2];
			end
		end
	end

	// master clock divider: half period equals baud integer part
	logic [BAUD_W-BAUD_FRAC_W-1:0] div_q;
	logic xck_int_q;
	logic [BAUD_W-BAUD_FRAC_W-1:0] baud_int;
	assign baud_int = cfg_in.baud[BAUD_W-1:BAUD_FRAC_W];
	logic active_q;
	logic got_byte;
	// the clock stops after the eighth sample, so a stalled frame sends no extra edges
	always_ff @(posedge clk_in) begin
		if (rst_in || !active_q || slave || got_byte) begin
			div_q <= '0;
			xck_int_q <= 1'b0;
		end else if (div_q + 1'b1 >= baud_int) begin
			div_q <= '0;
			xck_int_q <= !xck_int_q;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// raw clock level before pin inversion
	logic xck_raw, xck_raw_q;
	assign xck_raw = slave ? (xck_lvl_q ^ cfg_in.pin_inversion_enable) : xck_int_q;
	logic lead_edge, trail_edge;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			xck_raw_q <= 1'b0;
		end else begin
			xck_raw_q <= xck_raw;
		end
	end
	assign lead_edge = xck_raw && !xck_raw_q;
	assign trail_edge = !xck_raw && xck_raw_q;

	// edge roles: plain sync shifts on lead; spi phase 0 samples on lead
	logic shift_edge, sample_edge;
	logic sample_lead;
	assign sample_lead = cfg_in.mode == USCR_MODE_SPI && !cfg_in.clock_phase_select;
	assign shift_edge = sample_lead ? trail_edge : lead_edge;
	assign sample_edge = sample_lead ? lead_edge : trail_edge;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			serial_clock_pin_out <= 1'b0;
			serial_clock_pin_oe_out <= 1'b0;
		end else begin
			serial_clock_pin_out <= xck_int_q ^ cfg_in.pin_inversion_enable;
			serial_clock_pin_oe_out <= sync_mode && cfg_in.clk_master;
		end
	end

	// synchronous byte engine, eight bits, no framing bits
	logic [7:0] tx_head;
	logic tx_avail, tx_pop;
	logic [7:0] sh_tx_q, sh_rx_q;
	logic [3:0] bits_q;
	logic rx_push_ready;
	logic [7:0] rx_push_data;
	logic [7:0] tx_load;
	uscr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_data_in(tx_data_in),
		.wr_valid_in(tx_valid_in),
		.wr_ready_out(tx_ready_out),
		.rd_data_out(tx_head),
		.rd_valid_out(tx_avail),
		.rd_ready_in(tx_pop)
	);
	assign tx_pop = sync_mode && !active_q && tx_avail;

	function automatic logic [7:0] bit_rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			bit_rev[i] = v[7-i];
		end
	endfunction
	assign tx_load = cfg_in.bit_order_select ? tx_head : bit_rev(tx_head);

	// as master, stall the link instead of losing a byte when the receive buffer is full
	always_ff @(posedge clk_in) begin
		if (rst_in || !sync_mode) begin
			active_q <= 1'b0;
			sh_tx_q <= '0;
			sh_rx_q <= '0;
			bits_q <= '0;
			txd_out <= 1'b1;
		end else if (tx_pop) begin
			active_q <= 1'b1;
			// phase 0 samples on the first edge, so the first bit must already stand
			if (sample_lead) begin
				txd_out <= tx_load[0];
				sh_tx_q <= {1'b0, tx_load[7:1]};
			end else begin
				sh_tx_q <= tx_load;
			end
			bits_q <= '0;
		end else if (active_q) begin
			if (sample_edge && !got_byte) begin
				sh_rx_q <= {rxd_lvl_q, sh_rx_q[7:1]};
				bits_q <= bits_q + 1'b1;
			end
			if (shift_edge) begin
				txd_out <= sh_tx_q[0];
				sh_tx_q <= {1'b0, sh_tx_q[7:1]};
			end
			if (got_byte && rx_push_ready) begin
				active_q <= 1'b0;
			end
		end
	end
	assign got_byte = active_q && bits_q == SPI_FRAME_BITS;
	assign rx_push_data = cfg_in.bit_order_select ? sh_rx_q : bit_rev(sh_rx_q);

	logic [7:0] rx_fifo_data;
	logic rx_fifo_valid, rx_pop;
	uscr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_data_in(rx_push_data),
		.wr_valid_in(got_byte),
		.wr_ready_out(rx_push_ready),
		.rd_data_out(rx_fifo_data),
		.rd_valid_out(rx_fifo_valid),
		.rd_ready_in(rx_pop)
	);
	assign rx_pop = rx_fifo_valid && (!rx_valid_out || rx_ready_in);
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rx_valid_out <= 1'b0;
			rx_data_out <= '0;
		end else if (rx_pop) begin
			rx_valid_out <= 1'b1;
			rx_data_out <= rx_fifo_data;
		end else if (rx_ready_in) begin
			rx_valid_out <= 1'b0;
		end
	end

	// spi carries no error flags; this block never raises them itself
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			err_out <= '0;
			busy_out <= 1'b0;
		end else begin
			err_out <= '0;
			busy_out <= active_q;
		end
	end

	// asynchronous start-bit detection on oversampling ticks
	uscr_rx_state_t st_q;
	logic [4:0] scnt_q;
	logic [1:0] lows_q;
	logic prev_q;
	logic [4:0] spb, vfirst;
	assign spb = cfg_in.receive_speed_mode == RECEIVE_SPEED_MODE_DOUBLE ? SPB_DOUBLE : SPB_NORMAL;
	assign vfirst = cfg_in.receive_speed_mode == RECEIVE_SPEED_MODE_DOUBLE ?
		VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
	always_ff @(posedge clk_in) begin
		if (rst_in || sync_mode) begin
			st_q <= USCR_RX_IDLE;
			scnt_q <= '0;
			lows_q <= '0;
			prev_q <= 1'b1;
			start_ok_out <= 1'b0;
			bit_tick_out <= 1'b0;
		end else begin
			start_ok_out <= 1'b0;
			bit_tick_out <= 1'b0;
			if (sample_tick_in) begin
				prev_q <= rxd_lvl_q;
				case (st_q)
				USCR_RX_IDLE: begin
					if (prev_q && !rxd_lvl_q) begin
						st_q <= USCR_RX_START;
						scnt_q <= 5'h01;
						lows_q <= '0;
					end
				end
				USCR_RX_START: begin
					scnt_q <= scnt_q + 1'b1;
					if (scnt_q + 1'b1 >= vfirst && scnt_q + 1'b1 <= vfirst + 5'h02 &&
						!rxd_lvl_q && lows_q != 2'h3) begin
						lows_q <= lows_q + 1'b1;
					end
					if (scnt_q == vfirst + 5'h02) begin
						if (lows_q >= 2'h2) begin
							st_q <= USCR_RX_DATA;
							start_ok_out <= 1'b1;
							scnt_q <= 5'h03;
						end else begin
							st_q <= USCR_RX_IDLE;
						end
					end
				end
				USCR_RX_DATA: begin
					// recovered bit clock; data recovery outside re-arms by idle line
					if (scnt_q == spb) begin
						scnt_q <= 5'h01;
						bit_tick_out <= 1'b1;
					end else begin
						scnt_q <= scnt_q + 1'b1;
					end
					if (rxd_lvl_q && prev_q && scnt_q == spb) begin
						st_q <= USCR_RX_IDLE;
					end
				end
				default: st_q <= USCR_RX_IDLE;
				endcase
			end
		end
	end

	a_clock_oe_mode: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(slave) && !$past(rst_in) |-> !serial_clock_pin_oe_out)
		else $error("clock pin driven in slave mode");
	a_err_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		err_out == '0)
		else $error("error flags not zero");
	a_edges_apart: assert property (@(posedge clk_in) disable iff (rst_in)
		!(shift_edge && sample_edge))
		else $error("shift and sample on same edge");
	a_frame_eight: assert property (@(posedge clk_in) disable iff (rst_in)
		bits_q <= SPI_FRAME_BITS)
		else $error("frame longer than eight bits");
	a_start_bound: assert property (@(posedge clk_in) disable iff (rst_in)
		st_q == USCR_RX_START |-> scnt_q <= 5'h0C)
		else $error("start detection overran vote window");
	a_accept_vote: assert property (@(posedge clk_in) disable iff (rst_in)
		start_ok_out |-> $past(lows_q) >= 2'h2)
		else $error("start accepted without majority");
	a_idle_detect: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(st_q) == USCR_RX_IDLE && st_q == USCR_RX_START |-> $past(prev_q))
		else $error("detection without falling edge");
	a_div_bound: assert property (@(posedge clk_in) disable iff (rst_in)
		baud_int != '0 |-> div_q < baud_int || div_q == '0)
		else $error("divider overran");
	c_spi_byte: cover property (@(posedge clk_in) got_byte && rx_push_ready);
	c_start_ok: cover property (@(posedge clk_in) start_ok_out);
	c_start_rej: cover property (@(posedge clk_in)
		st_q == USCR_RX_START ##1 st_q == USCR_RX_IDLE);
	c_rx_full: cover property (@(posedge clk_in) got_byte && !rx_push_ready);
endmodule
`default_nettype wire

// >>> uscr_spi_slave.sv
`timescale 1ns/100ps
`default_nettype none
module uscr_spi_slave (
	// pins
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic clr_in,
	// edge roles
	input wire logic inv_in,
	input wire logic pha_in,
	input wire logic lsb_in,
	// capture
	output logic miso_out,
	output logic [7:0] byte_out,
	output logic done_out,
	output logic [3:0] nbits_out
);
	logic [7:0] sh = 8'h00;
	logic prev = 1'b0;
	initial begin
		byte_out = 8'h00;
		done_out = 1'b0;
		nbits_out = 4'h0;
	end
	// loopback: the master samples mid-hold, so its own bits return
	assign miso_out = mosi_in;
	always @(sck_in or clr_in) begin
		if (clr_in) begin
			nbits_out = 4'h0;
		end else if (sck_in !== prev && sck_in === (inv_in ~^ pha_in)) begin
			sh = {sh[6:0], mosi_in};
			nbits_out = nbits_out + 4'h1;
			if (nbits_out == 4'h8) begin
				nbits_out = 4'h0;
				byte_out = lsb_in ? {<<{sh}} : sh;
				done_out = ~done_out;
			end
		end
		prev = sck_in;
	end
endmodule
`default_nettype wire

// >>> uscr_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module uscr_top_test;
	import uscr_pkg::*;
	logic clk_in = 0, rst_in = 1, sck_tb = 0, rx_tb = 1, tick = 0, p_clr = 1;
	logic tx_valid = 0, rx_ready = 1, ref_seen;
	uscr_cfg_t cfg = '0;
	logic [7:0] tx_data = 0, rx_data, pbyte, ev;
	logic sck_o, sck_oe, txd, st_ok, busy, tx_ready, rx_valid, done, miso;
	logic [3:0] nbits;
	uscr_err_t err;
	logic [15:0] lf = 16'hF3F0;
	logic [7:0] pq[$], rq[$];
	int bad_count = 0, n_compared = 0, starts = 0;
	time t0 = 0;
	wire logic sck = sck_oe ? sck_o : sck_tb;
	wire logic rxd = (cfg.mode == USCR_MODE_ASYNC) ? rx_tb : miso;
	always #50 clk_in = ~clk_in;
	always @(negedge clk_in) tick <= ~tick;
	uscr_top i_uscr_top (.clk_in(clk_in), .rst_in(rst_in), .cfg_in(cfg),
		.serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o),
		.serial_clock_pin_oe_out(sck_oe), .rxd_in(rxd), .txd_out(txd),
		.tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
		.sample_tick_in(tick), .start_ok_out(st_ok), .bit_tick_out(),
		.err_out(err), .busy_out(busy));
	// sync mode behaves like phase one for the far side
	uscr_spi_slave i_uscr_spi_slave (.sck_in(sck), .mosi_in(txd), .clr_in(p_clr),
		.inv_in(cfg.pin_inversion_enable),
		.pha_in(cfg.clock_phase_select | (cfg.mode == USCR_MODE_SYNC)),
		.lsb_in(cfg.bit_order_select), .miso_out(miso), .byte_out(pbyte),
		.done_out(done), .nbits_out(nbits));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	always @(posedge clk_in) begin
		if (st_ok === 1'b1) starts++;
		if (rx_valid === 1'b1 && rx_ready) begin
			ev = rq.pop_front();
			`CHK("rx_data", ev, rx_data)
		end
		if (!rst_in) `CHK("err", 3'h0, err)
	end
	always @(done) begin
		ev = pq.pop_front();
		`CHK("wire_byte", ev, pbyte)
	end
	always @(nbits) begin
		if (cfg.clk_master && !p_clr && nbits != 4'h1)
			`CHK("bit_period", 2 * (cfg.baud >> BAUD_FRAC_W) * 100, $time - t0)
		t0 = $time;
	end
	task automatic summarize();
		if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic rst_dut();
		rst_in = 1;
		p_clr = 1;
		repeat (5) @(negedge clk_in);
		`CHK("oe_rst", 1'b0, sck_oe)
		`CHK("txd_rst", 1'b1, txd)
		rst_in = 0;
		repeat (4) @(negedge clk_in);
		p_clr = 0;
	endtask
	task automatic send(input logic [7:0] b);
		int k;
		k = 0;
		while (tx_ready !== 1'b1 && k < 2000) begin
			@(negedge clk_in);
			k++;
		end
		tx_valid = 1;
		tx_data = b;
		pq.push_back(b);
		rq.push_back(b);
		@(negedge clk_in);
		tx_valid = 0;
		@(negedge clk_in);
	endtask
	task automatic drain();
		int k;
		k = 0;
		while ((rq.size() != 0 || busy !== 1'b0) && k < 20000) begin
			@(negedge clk_in);
			k++;
		end
		`CHK("drained", 0, rq.size())
	endtask
	task automatic run_master(input uscr_mode_t m, input logic inv, pha, lsb);
		cfg = '0;
		cfg.mode = m;
		cfg.clk_master = 1;
		cfg.pin_inversion_enable = inv;
		cfg.clock_phase_select = pha;
		cfg.bit_order_select = lsb;
		cfg.baud = 16'h0200;
		rst_dut();
		`CHK("oe_master", 1'b1, sck_oe)
		send(8'h01);
		repeat (2) begin
			lf = lfsr(lf);
			send(lf[7:0]);
		end
		drain();
	endtask
	task automatic async_try(input logic dbl, input int low, input int n);
		cfg = '0;
		cfg.receive_speed_mode = dbl ? RECEIVE_SPEED_MODE_DOUBLE : RECEIVE_SPEED_MODE_NORMAL;
		rst_dut();
		starts = 0;
		rx_tb = 0;
		repeat (2 * low) @(negedge clk_in);
		rx_tb = 1;
		repeat (60) @(negedge clk_in);
		`CHK("start_ok", n, starts)
	endtask
	initial begin
		#5000000;
		bad_count++;
		summarize();
	end
	initial begin
		rst_dut();
		for (int m = 0; m < 10; m++)
			run_master(m < 8 ? USCR_MODE_SPI : USCR_MODE_SYNC, m[0], m[1], m[2]);
		// fill until the transmit side refuses while the receive side stalls
		rx_ready = 0;
		ref_seen = 0;
		for (int k = 0; k < 80 && !ref_seen; k++) begin
			if (tx_ready === 1'b1) begin
				lf = lfsr(lf);
				tx_data = lf[7:0];
				tx_valid = 1;
				pq.push_back(lf[7:0]);
				rq.push_back(lf[7:0]);
			end else begin
				tx_valid = 0;
				ref_seen = 1;
			end
			@(negedge clk_in);
		end
		`CHK("tx_full", 1'b1, ref_seen)
		repeat (300) @(negedge clk_in);
		rx_ready = 1;
		drain();
		// slave: clock from the far side, slower than a quarter of clk
		cfg = '0;
		cfg.mode = USCR_MODE_SYNC;
		cfg.baud = 16'hFFC0;
		rst_dut();
		`CHK("oe_slave", 1'b0, sck_oe)
		send(8'hA5);
		repeat (8) begin
			repeat (8) @(negedge clk_in);
			sck_tb = 1;
			repeat (8) @(negedge clk_in);
			sck_tb = 0;
		end
		drain();
		async_try(0, 9, 1);
		async_try(0, 8, 0);
		async_try(1, 5, 1);
		async_try(1, 4, 0);
		summarize();
	end
endmodule
`default_nettype wire
